// ---- src/pfn_feedback.sv ----
// performance feedback status, log, counter and notification logic
`default_nettype none

module pfn_feedback #(
  parameter int unsigned REPORT_GAP_CYCLES = pfn_pkg::REPORT_GAP_CYCLES,
  parameter int unsigned DIP_FILTER_CYCLES = pfn_pkg::DIP_FILTER_CYCLES
) (
  input wire logic clock_i, // 20 MHz core clock
  input wire logic rst_n_i, // synchronous reset, active low
  input wire logic reg_wr_i, // register write strobe
  input wire logic reg_rd_i, // register read strobe
  input wire logic [1:0] reg_sel_i, // register select
  input wire logic [63:0] reg_wdata_i, // write data
  input wire logic [7:0] sustain_level_i, // sustainable level reported
  input wire logic [7:0] floor_level_i, // requested minimum level
  input wire logic [7:0] run_level_i, // level actually delivered
  input wire logic actual_tick_i, // actual-cycle counter advances
  input wire logic productive_i, // this cycle counts as productive
  input wire logic cur_limit_i, // current limit being exceeded
  input wire logic xdom_limit_i, // other domain is limiting
  output logic [63:0] reg_rdata_o, // read data
  output logic reg_rvalid_o, // read data valid pulse
  output logic thermal_irq_o // thermal vector request pulse
);
  // ****************************************************************
  // helpers
  // ****************************************************************
  // write-zero-to-clear with set winning over the clear
  function automatic logic w0c(input logic flag, input logic set_ev,
                               input logic wr, input logic wbit);
    w0c = set_ev | (flag & ~(wr & ~wbit));
  endfunction

  function automatic logic [31:0] dec_sat(input logic [31:0] v);
    dec_sat = (v == 32'h0) ? 32'h0 : v - 32'h1;
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  logic floor_change_flag;
  logic below_floor_flag;
  logic cur_limit_status;
  logic cur_limit_log;
  logic xdom_status;
  logic xdom_log;
  logic [7:0] reported_level;
  logic [31:0] floor_gap_timer;
  logic [31:0] below_gap_timer;
  logic [31:0] dip_timer;
  logic [63:0] productive_cycle_count;
  logic en_floor_change;
  logic en_below_floor;
  logic [63:0] rdata;
  logic rvalid;
  logic irq;

  logic next_floor_change_flag;
  logic next_below_floor_flag;
  logic next_cur_limit_status;
  logic next_cur_limit_log;
  logic next_xdom_status;
  logic next_xdom_log;
  logic [7:0] next_reported_level;
  logic [31:0] next_floor_gap_timer;
  logic [31:0] next_below_gap_timer;
  logic [31:0] next_dip_timer;
  logic [63:0] next_productive_cycle_count;
  logic next_en_floor_change;
  logic next_en_below_floor;
  logic [63:0] next_rdata;
  logic next_rvalid;
  logic next_irq;

  logic wr_status;
  logic wr_thermal;
  logic wr_enable;
  logic floor_set;
  logic below_set;
  logic sustained_dip;

  assign wr_status = reg_wr_i && reg_sel_i == pfn_pkg::SEL_FEEDBACK_STATUS;
  assign wr_thermal = reg_wr_i && reg_sel_i == pfn_pkg::SEL_THERMAL_STATUS;
  assign wr_enable = reg_wr_i && reg_sel_i == pfn_pkg::SEL_IRQ_ENABLE;

  // ****************************************************************
  // event detection
  // ****************************************************************
  always_comb begin
    next_dip_timer = dip_timer;
    next_floor_gap_timer = dec_sat(floor_gap_timer);
    next_below_gap_timer = dec_sat(below_gap_timer);
    next_reported_level = reported_level;
    // the dip timer saturates, so a floor that stays above the
    // delivered level re-reports once the hold-off has ended and the flag is cleared
    // dip must outlast filter
    if (run_level_i < floor_level_i) begin
      if (dip_timer < DIP_FILTER_CYCLES) begin
        next_dip_timer = dip_timer + 32'h1;
      end
    end else begin
      next_dip_timer = 32'h0;
    end
    sustained_dip = (dip_timer >= DIP_FILTER_CYCLES);
    // a level that moves and returns inside the hold-off is never
    // reported: only the latest level is compared
    // set only from clear state
    floor_set = (sustain_level_i != reported_level) && !floor_change_flag
      && (floor_gap_timer == 32'h0);
    // a floor above sustainable keeps dipping
    below_set = sustained_dip && !below_floor_flag
      && (below_gap_timer == 32'h0);
    if (floor_set) begin
      next_reported_level = sustain_level_i;
      next_floor_gap_timer = REPORT_GAP_CYCLES;
    end
    if (below_set) begin
      next_below_gap_timer = REPORT_GAP_CYCLES;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      dip_timer <= 32'h0;
      floor_gap_timer <= 32'h0;
      below_gap_timer <= 32'h0;
      reported_level <= pfn_pkg::LEVEL_RESET;
    end else begin
      dip_timer <= next_dip_timer;
      floor_gap_timer <= next_floor_gap_timer;
      below_gap_timer <= next_below_gap_timer;
      reported_level <= next_reported_level;
    end
  end

  // ****************************************************************
  // status and log bits
  // ****************************************************************
  always_comb begin
    next_floor_change_flag = w0c(floor_change_flag, floor_set, wr_status,
      reg_wdata_i[pfn_pkg::FLOOR_CHANGE_BIT]);
    next_below_floor_flag = w0c(below_floor_flag, below_set, wr_status,
      reg_wdata_i[pfn_pkg::BELOW_FLOOR_BIT]);
    next_cur_limit_status = cur_limit_i;
    next_cur_limit_log = w0c(cur_limit_log, cur_limit_i, wr_thermal,
      reg_wdata_i[pfn_pkg::CUR_LIMIT_LOG_BIT]);
    next_xdom_status = xdom_limit_i;
    next_xdom_log = w0c(xdom_log, xdom_limit_i, wr_thermal,
      reg_wdata_i[pfn_pkg::XDOM_LOG_BIT]);
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      floor_change_flag <= 1'b0;
      below_floor_flag <= 1'b0;
      cur_limit_status <= 1'b0;
      cur_limit_log <= 1'b0;
      xdom_status <= 1'b0;
      xdom_log <= 1'b0;
    end else begin
      floor_change_flag <= next_floor_change_flag;
      below_floor_flag <= next_below_floor_flag;
      cur_limit_status <= next_cur_limit_status;
      cur_limit_log <= next_cur_limit_log;
      xdom_status <= next_xdom_status;
      xdom_log <= next_xdom_log;
    end
  end

  // ****************************************************************
  // productive cycle counter
  // ****************************************************************
  always_comb begin
    next_productive_cycle_count = productive_cycle_count;
    // gated by actual-cycle tick
    // wraps at the top; software only works with deltas
    // no dependence on control enable
    if (actual_tick_i && productive_i) begin
      next_productive_cycle_count = productive_cycle_count + 64'h1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      productive_cycle_count <= pfn_pkg::COUNT_RESET;
    end else begin
      productive_cycle_count <= next_productive_cycle_count;
    end
  end

  // ****************************************************************
  // interrupt enables and notification
  // ****************************************************************
  always_comb begin
    next_en_floor_change = en_floor_change;
    next_en_below_floor = en_below_floor;
    if (wr_enable) begin
      next_en_floor_change = reg_wdata_i[pfn_pkg::EN_FLOOR_CHANGE_BIT];
      next_en_below_floor = reg_wdata_i[pfn_pkg::EN_BELOW_FLOOR_BIT];
    end
    // enabling late does not replay a flag that is already set
    // request on flag rise
    next_irq = (floor_set && en_floor_change)
      || (below_set && en_below_floor);
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      en_floor_change <= 1'b0;
      en_below_floor <= 1'b0;
      irq <= 1'b0;
    end else begin
      en_floor_change <= next_en_floor_change;
      en_below_floor <= next_en_below_floor;
      irq <= next_irq;
    end
  end

  // ****************************************************************
  // read path
  // ****************************************************************
  // reads show state before any write in the same cycle
  always_comb begin
    next_rdata = pfn_pkg::ZERO_WORD;
    next_rvalid = reg_rd_i;
    if (reg_rd_i) begin
      case (reg_sel_i)
        pfn_pkg::SEL_FEEDBACK_STATUS: begin
          next_rdata[pfn_pkg::FLOOR_CHANGE_BIT] = floor_change_flag;
          next_rdata[pfn_pkg::BELOW_FLOOR_BIT] = below_floor_flag;
        end
        pfn_pkg::SEL_THERMAL_STATUS: begin
          next_rdata[pfn_pkg::CUR_LIMIT_STATUS_BIT] = cur_limit_status;
          next_rdata[pfn_pkg::CUR_LIMIT_LOG_BIT] = cur_limit_log;
          next_rdata[pfn_pkg::XDOM_STATUS_BIT] = xdom_status;
          next_rdata[pfn_pkg::XDOM_LOG_BIT] = xdom_log;
        end
        pfn_pkg::SEL_PRODUCTIVE_COUNT: begin
          next_rdata = productive_cycle_count;
        end
        pfn_pkg::SEL_IRQ_ENABLE: begin
          next_rdata[pfn_pkg::EN_FLOOR_CHANGE_BIT] = en_floor_change;
          next_rdata[pfn_pkg::EN_BELOW_FLOOR_BIT] = en_below_floor;
        end
        default: begin
          next_rdata = pfn_pkg::ZERO_WORD;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      rdata <= pfn_pkg::ZERO_WORD;
      rvalid <= 1'b0;
    end else begin
      rdata <= next_rdata;
      rvalid <= next_rvalid;
    end
  end

  assign reg_rdata_o = rdata;
  assign reg_rvalid_o = rvalid;
  assign thermal_irq_o = irq;
endmodule
`default_nettype wire

// ---- src/pfn_pkg.sv ----
// constants for the performance feedback notification register bank
`default_nettype none
package pfn_pkg;
  // ****************************************************************
  // register select codes on the register access port
  // ****************************************************************
  localparam logic [1:0] SEL_FEEDBACK_STATUS = 2'h0;
  localparam logic [1:0] SEL_THERMAL_STATUS = 2'h1;
  localparam logic [1:0] SEL_PRODUCTIVE_COUNT = 2'h2;
  localparam logic [1:0] SEL_IRQ_ENABLE = 2'h3;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int FLOOR_CHANGE_BIT = 0;
  localparam int BELOW_FLOOR_BIT = 2;
  localparam int CUR_LIMIT_STATUS_BIT = 12;
  localparam int CUR_LIMIT_LOG_BIT = 13;
  localparam int XDOM_STATUS_BIT = 14;
  localparam int XDOM_LOG_BIT = 15;
  localparam int EN_FLOOR_CHANGE_BIT = 0;
  localparam int EN_BELOW_FLOOR_BIT = 1;

  // ****************************************************************
  // widths and reset values
  // ****************************************************************
  localparam int DATA_W = 64;
  localparam int LEVEL_W = 8;
  localparam int TIMER_W = 32;
  localparam logic [DATA_W-1:0] ZERO_WORD = 64'h0;
  localparam logic [LEVEL_W-1:0] LEVEL_RESET = 8'h00;
  localparam logic [DATA_W-1:0] COUNT_RESET = 64'h0;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CLOCK_HZ = 20_000_000;
  localparam int unsigned REPORT_GAP_S = 1;
  localparam int unsigned REPORT_GAP_CYCLES = REPORT_GAP_S * CLOCK_HZ;
  // a dip shorter than this is a normal one, e.g. after idle exit
  localparam int unsigned DIP_FILTER_US = 2000;
  localparam int unsigned DIP_FILTER_CYCLES =
    DIP_FILTER_US * (CLOCK_HZ / 1_000_000);
endpackage
`default_nettype wire

// ---- verif/pfn_feedback_chk.sv ----
// port assertions for the feedback register bank
`default_nettype none
module pfn_feedback_chk (
  input wire logic clock_i, // clock
  input wire logic rst_n_i, // reset
  input wire logic reg_rd_i, // read strobe
  input wire logic [1:0] reg_sel_i, // select
  input wire logic actual_tick_i, // tick
  input wire logic productive_i, // productive
  input wire logic cur_limit_i, // current limit
  input wire logic xdom_limit_i, // other domain
  input wire logic [63:0] reg_rdata_o, // read data
  input wire logic reg_rvalid_o, // read valid
  input wire logic thermal_irq_o // interrupt
);
  // ****************
  // read decodes
  // ****************
  logic rd_st, rd_th, rd_ct;
  assign rd_st = reg_rd_i && reg_sel_i == pfn_pkg::SEL_FEEDBACK_STATUS;
  assign rd_th = reg_rd_i && reg_sel_i == pfn_pkg::SEL_THERMAL_STATUS;
  assign rd_ct = reg_rd_i && reg_sel_i == pfn_pkg::SEL_PRODUCTIVE_COUNT;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  rd_answer_a:
    assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("read not answered");
  rsvd_zero_a:
    assert property (rd_st |=> reg_rdata_o[63:3] == 61'h0 && !reg_rdata_o[1])
    else $error("reserved status bits set");
  // live bits lag their input by one cycle
  cur_live_a:
    assert property (rd_th && $past(rst_n_i) |=>
      reg_rdata_o[12] == $past(cur_limit_i, 2))
    else $error("current limit status wrong");
  cur_log_a:
    assert property ($past(cur_limit_i) && $past(rst_n_i) && rd_th |=>
      reg_rdata_o[13])
    else $error("current limit log missed");
  xdom_live_a:
    assert property (rd_th && $past(rst_n_i) |=>
      reg_rdata_o[14] == $past(xdom_limit_i, 2))
    else $error("cross domain status wrong");
  xdom_log_a:
    assert property ($past(xdom_limit_i) && $past(rst_n_i) && rd_th |=>
      reg_rdata_o[15])
    else $error("cross domain log missed");
  count_step_a:
    assert property (rd_ct ##1 rd_ct |=> reg_rdata_o ==
      $past(reg_rdata_o) + 64'($past(actual_tick_i && productive_i, 2)))
    else $error("counter step wrong");
  irq_quiet_a:
    assert property ($rose(rst_n_i) |-> !thermal_irq_o [*2])
    else $error("interrupt with enables at reset");
  idle_zero_a:
    assert property (!reg_rd_i |=> !reg_rvalid_o && reg_rdata_o == 64'h0)
    else $error("read port not idle");
  cover property (thermal_irq_o);
  cover property (rd_ct ##1 rd_ct);
  cover property (rd_st ##1 reg_rdata_o[2]);
endmodule
bind pfn_feedback pfn_feedback_chk pfn_feedback_chk_i (.clock_i, .rst_n_i,
  .reg_rd_i, .reg_sel_i, .actual_tick_i, .productive_i, .cur_limit_i,
  .xdom_limit_i, .reg_rdata_o, .reg_rvalid_o, .thermal_irq_o);
`default_nettype wire

// ---- verif/tb_top.sv ----
// self-checking bench for the feedback register bank
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************
  // stimulus and design
  // ****************
  localparam int GAP = 20;
  localparam int DIP = 4;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic [1:0] reg_sel_i = 2'h0;
  logic [63:0] reg_wdata_i = 64'h0, reg_rdata_o, rd, exp_cnt;
  logic [7:0] sust = 8'h00, flr = 8'h00, run = 8'h00;
  logic tick = 1'b0, prod = 1'b0, cur = 1'b0, xd = 1'b0;
  logic reg_rvalid_o, thermal_irq_o;
  int mismatches = 0, checks_done = 0, irqs = 0;
  always #25 clock_i = ~clock_i;
  pfn_feedback #(.REPORT_GAP_CYCLES(GAP), .DIP_FILTER_CYCLES(DIP))
  pfn_feedback_i (.clock_i, .rst_n_i, .reg_wr_i, .reg_rd_i, .reg_sel_i,
    .reg_wdata_i, .sustain_level_i(sust), .floor_level_i(flr),
    .run_level_i(run), .actual_tick_i(tick), .productive_i(prod),
    .cur_limit_i(cur), .xdom_limit_i(xd), .reg_rdata_o, .reg_rvalid_o,
    .thermal_irq_o);
  // counted off the edge so the registered pulse has settled
  always @(negedge clock_i) if (thermal_irq_o === 1'b1) irqs++;
  always @(posedge clock_i) begin
    if (!rst_n_i) exp_cnt <= 64'h0;
    else if (tick && prod) exp_cnt <= exp_cnt + 64'h1;
  end
  // ****************
  // tasks
  // ****************
  function automatic logic [63:0] therm_exp(input logic c, input logic x,
                                            input logic live);
    therm_exp = 64'h0;
    therm_exp[pfn_pkg::CUR_LIMIT_STATUS_BIT] = c & live;
    therm_exp[pfn_pkg::CUR_LIMIT_LOG_BIT] = c;
    therm_exp[pfn_pkg::XDOM_STATUS_BIT] = x & live;
    therm_exp[pfn_pkg::XDOM_LOG_BIT] = x;
  endfunction
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  task automatic wr(input logic [1:0] s, input logic [63:0] d);
    reg_wr_i <= 1'b1;
    reg_sel_i <= s;
    reg_wdata_i <= d;
    cyc(1);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rdx(input logic [1:0] s);
    int k;
    reg_rd_i <= 1'b1;
    reg_sel_i <= s;
    cyc(1);
    reg_rd_i <= 1'b0;
    // answer taken at the edge that closes its one-cycle window
    for (k = 0; k < 3; k++) begin
      cyc(1);
      if (reg_rvalid_o === 1'b1) break;
    end
    if (k == 3) begin
      chk(reg_rvalid_o, 1'b1);
      final_report();
    end
    rd = reg_rdata_o;
  endtask
  task automatic wait_irq(input int n);
    int k;
    for (k = 0; k < 40 && irqs < n; k++) cyc(1);
    chk(irqs, n);
    if (irqs < n) final_report();
  endtask
  // ****************
  // scenarios
  // ****************
  initial begin
    int i;
    logic [63:0] d;
    void'($urandom(53));
    cyc(12);
    rst_n_i <= 1'b1;
    cyc(1);
    rdx(3);
    chk(rd, 64'h0);
    rdx(0);
    chk(rd, 64'h0);
    d = {$urandom(), $urandom()} | 64'h3;
    wr(3, d);
    rdx(3);
    chk(rd, 64'h3);
    sust <= 8'($urandom_range(1, 200));
    wait_irq(1);
    rdx(0);
    chk(rd, 64'h1);
    // change while flag set must wait for the clear
    sust <= sust + 8'h11;
    cyc(GAP + 5);
    chk(irqs, 1);
    wr(0, 64'h5);
    rdx(0);
    chk(rd, 64'h1);
    wr(0, 64'h0);
    wait_irq(2);
    wr(0, 64'h0);
    sust <= sust + 8'h22;
    cyc(3);
    rdx(0);
    chk(rd, 64'h0);
    wait_irq(3);
    wr(0, 64'h0);
    flr <= 8'h10;
    run <= 8'h0f;
    cyc(2);
    run <= 8'h10;
    cyc(3);
    rdx(0);
    chk(rd, 64'h0);
    run <= 8'h08;
    wait_irq(4);
    rdx(0);
    chk(rd, 64'h4);
    wr(0, 64'h0);
    wait_irq(5);
    run <= 8'h10;
    wr(3, 64'h0);
    sust <= sust + 8'h01;
    cyc(4);
    chk(irqs, 5);
    rdx(0);
    chk(rd[0], 1'b1);
    for (i = 0; i < 2; i++) begin
      cur <= (i == 0);
      xd <= (i == 1);
      cyc(2);
      rdx(1);
      chk(rd, therm_exp(i == 0, i == 1, 1'b1));
      cur <= 1'b0;
      xd <= 1'b0;
      cyc(2);
      rdx(1);
      chk(rd, therm_exp(i == 0, i == 1, 1'b0));
      wr(1, 64'h0);
      rdx(1);
      chk(rd, 64'h0);
    end
    // back-to-back counter reads while random ticks run
    reg_sel_i <= 2'h2;
    for (i = 0; i < 200; i++) begin
      tick <= 1'($urandom_range(0, 1));
      prod <= 1'($urandom_range(0, 1));
      reg_rd_i <= (i % 16) < 2;
      cyc(1);
    end
    tick <= 1'b0;
    reg_rd_i <= 1'b0;
    cyc(2);
    rdx(2);
    chk(rd, exp_cnt);
    wr(2, {64{1'b1}});
    rdx(2);
    chk(rd, exp_cnt);
    final_report();
  end
endmodule
`default_nettype wire
